// File: design/csoc_pkg.sv
// shared constants, types and register map of the sensing control block
package csoc_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] CSOC_OFF_CTRL0 = 8'h00; // sense_control_zero
    localparam logic [7:0] CSOC_OFF_CTRL1 = 8'h04; // sense_control_one
    localparam logic [7:0] CSOC_OFF_T1CTL = 8'h08; // timer_one_control
    localparam logic [7:0] CSOC_OFF_TAUX  = 8'h0C; // timer selection extras

    // sense_control_zero field positions
    localparam int CSOC_B_ENABLE = 7; // sense_module_enable
    localparam int CSOC_B_REFM   = 6; // reference_mode_select
    localparam int CSOC_B_RNG_HI = 3; // current_range_field msb
    localparam int CSOC_B_RNG_LO = 2; // current_range_field lsb
    localparam int CSOC_B_PHASE  = 1; // oscillator_phase_status, read only
    localparam int CSOC_B_T0EXT  = 0; // timer_zero_ext_source_select

    // timer_one_control field positions
    localparam int CSOC_B_T1CS_HI = 7; // timer_one_clock_source msb
    localparam int CSOC_B_T1CS_LO = 6; // timer_one_clock_source lsb
    localparam int CSOC_B_T1ON    = 0; // timer_one_on

    // timer selection extras field positions
    localparam int CSOC_B_T0CS = 0; // timer_zero_clock_source
    localparam int CSOC_B_T1GE = 1; // timer_one_gate_enable

    // writable masks, reserved bits stay zero
    localparam logic [7:0] CSOC_MSK_CTRL0 = 8'hCD;
    localparam logic [7:0] CSOC_MSK_CTRL1 = 8'h0F;
    localparam logic [7:0] CSOC_MSK_T1CTL = 8'hFD;
    localparam logic [7:0] CSOC_MSK_TAUX  = 8'h03;

    // reset values
    localparam logic [7:0] CSOC_RST_CTRL0 = 8'h00;
    localparam logic [7:0] CSOC_RST_CTRL1 = 8'h00;
    localparam logic [7:0] CSOC_RST_T1CTL = 8'h00;
    localparam logic [7:0] CSOC_RST_TAUX  = 8'h00;

    // range codes, timer one source codes and channel count
    localparam logic [1:0] CSOC_RNG_ZERO  = 2'h0; // off or noise detection
    localparam logic [1:0] CSOC_RNG_LOW   = 2'h1;
    localparam logic [1:0] CSOC_RNG_MED   = 2'h2;
    localparam logic [1:0] CSOC_T1CS_SNS  = 2'h3; // sensing oscillator
    localparam logic [1:0] CSOC_T1CS_FOSC = 2'h1; // system clock
    localparam logic [1:0] CSOC_T1CS_PIN  = 2'h2; // timer one pin
    localparam int         CSOC_NCHAN     = 8;

    // system clock divide for the instruction-rate tick
    localparam logic [1:0] CSOC_FOSC4_LAST = 2'h3;

    // current mode of the oscillator, one-hot
    typedef enum logic [4:0] {
        CSOC_CUR_OFF   = 5'b00001,
        CSOC_CUR_NOISE = 5'b00010,
        CSOC_CUR_LOW   = 5'b00100,
        CSOC_CUR_MED   = 5'b01000,
        CSOC_CUR_HIGH  = 5'b10000
    } csoc_cur_t;

    // control bundle toward the analog oscillator and pad mux
    typedef struct packed {
        logic [7:0] chan_en;    // one-hot pad connection
        logic       osc_on;     // oscillator core powered
        logic       src_off;    // constant current source disabled
        logic       ref_lo_dac; // lower threshold from dac, else ground
        logic       ref_hi_vref; // upper from voltage reference, else supply
        csoc_cur_t  cur_mode;   // current setting
    } csoc_analog_t;

endpackage

// File: design/csoc_sync.sv
// three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps
module csoc_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    logic ff1_reg, ff2_reg, ff3_reg;       // raw chain
    logic lvl_reg, lvl_next;               // accepted level
    logic rise_reg, rise_next;             // one-cycle rise pulse

    // a change only counts once the second and third stage agree
    always_comb begin
        lvl_next  = lvl_reg;
        rise_next = 1'b0;
        if (ff2_reg == ff3_reg) begin
            lvl_next  = ff3_reg;
            rise_next = ff3_reg & ~lvl_reg;
        end
    end

    // stage registers, first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ff1_reg  <= 1'b0;
            ff2_reg  <= 1'b0;
            ff3_reg  <= 1'b0;
            lvl_reg  <= 1'b0;
            rise_reg <= 1'b0;
        end else begin
            ff1_reg  <= async_in;
            ff2_reg  <= ff1_reg;
            ff3_reg  <= ff2_reg;
            lvl_reg  <= lvl_next;
            rise_reg <= rise_next;
        end
    end

    assign level = lvl_reg;
    assign rise  = rise_reg;
endmodule // csoc_sync

// File: design/csoc_top.sv
// sensing oscillator control: apb registers, analog control, timer ticks
// Contract
// - reference-mode bit picks variable or fixed references
// - fixed mode: low ground, high supply
// - variable mode: low from dac, high voltage reference
// - decode current range per reference mode
// - noise mode: source off, oscillator stays on
// - readable bit shows sourcing or sinking phase
// - enabled module connects the selected channel pin
// - ext select set, clock source clear: timer zero
// - timer one source 11 uses sensing oscillator
// - timer one gated by on and gate enable
// - enable bit switches the sensing module
// - disabled module connects no channel at all
// - codes 0-7 pick channels, upper codes reserved
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module csoc_top (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  osc_comp,
    input  wire logic                  t0_pin,
    input  wire logic                  t1_pin,
    input  wire logic                  t1_gate,
    output csoc_pkg::csoc_analog_t     analog_ctrl,
    output logic                       tmr0_tick,
    output logic                       tmr1_tick
);
    // software-visible control registers
    logic [7:0]  ctrl0_reg, ctrl0_next;     // sense_control_zero
    logic [7:0]  ctrl1_reg, ctrl1_next;     // sense_control_one
    logic [7:0]  t1ctl_reg, t1ctl_next;     // timer_one_control
    logic [7:0]  taux_reg,  taux_next;      // timer selection extras
    // bus answer registers
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    // block outputs
    csoc_pkg::csoc_analog_t analog_reg, analog_next;
    logic        t0tick_reg, t0tick_next;
    logic        t1tick_reg, t1tick_next;
    logic [1:0]  div_reg, div_next;         // fosc/4 divider
    // synchronised pins
    logic        phase_lvl, osc_rise;       // comparator output
    logic        t0p_rise, t1p_rise;        // external timer pins
    logic        gate_lvl;                  // timer one gate level
    // bus decode helpers
    logic        setup_ph, access_ph, mapped;
    logic [7:0]  rd_byte;
    logic [7:0]  chan_hot;

    // pins from outside the clock domain
    csoc_sync u_sync_osc (.clk(clk), .rst_n(rst_n), .async_in(osc_comp),
                          .level(phase_lvl), .rise(osc_rise));
    csoc_sync u_sync_t0 (.clk(clk), .rst_n(rst_n), .async_in(t0_pin),
                         .level(), .rise(t0p_rise));
    csoc_sync u_sync_t1 (.clk(clk), .rst_n(rst_n), .async_in(t1_pin),
                         .level(), .rise(t1p_rise));
    csoc_sync u_sync_gt (.clk(clk), .rst_n(rst_n), .async_in(t1_gate),
                         .level(gate_lvl), .rise());

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable & pready_reg;

    // address decode and read mux, status bit is live oscillator phase
    always_comb begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        case (paddr)
            csoc_pkg::CSOC_OFF_CTRL0: begin
                rd_byte = ctrl0_reg;
                rd_byte[csoc_pkg::CSOC_B_PHASE] = phase_lvl;
            end
            csoc_pkg::CSOC_OFF_CTRL1: rd_byte = ctrl1_reg;
            csoc_pkg::CSOC_OFF_T1CTL: rd_byte = t1ctl_reg;
            csoc_pkg::CSOC_OFF_TAUX:  rd_byte = taux_reg;
            default:                  mapped  = 1'b0;
        endcase
    end

    // apb answer: ready in the first access cycle, no wait states
    always_comb begin
        pready_next  = setup_ph;
        pslverr_next = setup_ph & ~mapped;
        prdata_next  = prdata_reg;
        if (setup_ph) begin
            // unmapped reads return zero with an error
            prdata_next = {24'h00_0000, rd_byte};
        end
    end

    // register writes land on the access edge, low byte lane only
    always_comb begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        t1ctl_next = t1ctl_reg;
        taux_next  = taux_reg;
        if (access_ph && pwrite && pstrb[0]) begin
            case (paddr)
                csoc_pkg::CSOC_OFF_CTRL0:
                    ctrl0_next = pwdata[7:0] & csoc_pkg::CSOC_MSK_CTRL0;
                csoc_pkg::CSOC_OFF_CTRL1:
                    ctrl1_next = pwdata[7:0] & csoc_pkg::CSOC_MSK_CTRL1;
                csoc_pkg::CSOC_OFF_T1CTL:
                    t1ctl_next = pwdata[7:0] & csoc_pkg::CSOC_MSK_T1CTL;
                csoc_pkg::CSOC_OFF_TAUX:
                    taux_next  = pwdata[7:0] & csoc_pkg::CSOC_MSK_TAUX;
                default: ; // unmapped writes are dropped
            endcase
        end
    end

    // channel decode, one bit per pad
    genvar gi;
    generate
        for (gi = 0; gi < csoc_pkg::CSOC_NCHAN; gi++) begin : g_chan
            // upper codes match no pad, so reserved codes connect nothing
            assign chan_hot[gi] = ctrl0_reg[csoc_pkg::CSOC_B_ENABLE] &&
                                  (ctrl1_reg[3:0] == 4'(gi));
        end
    endgenerate

    // analog control decode from the control registers
    always_comb begin
        logic       en;
        logic       vref;
        logic [1:0] rng;
        en   = ctrl0_reg[csoc_pkg::CSOC_B_ENABLE];
        vref = ctrl0_reg[csoc_pkg::CSOC_B_REFM];
        rng  = ctrl0_reg[csoc_pkg::CSOC_B_RNG_HI:csoc_pkg::CSOC_B_RNG_LO];
        analog_next = analog_reg;
        // disabled module ignores the channel field
        analog_next.chan_en    = en ? chan_hot : 8'h00;
        analog_next.ref_lo_dac = vref;
        analog_next.ref_hi_vref = vref;
        // current setting depends on reference mode for code zero
        case (rng)
            csoc_pkg::CSOC_RNG_ZERO:
                analog_next.cur_mode = vref ? csoc_pkg::CSOC_CUR_NOISE
                                            : csoc_pkg::CSOC_CUR_OFF;
            csoc_pkg::CSOC_RNG_LOW: analog_next.cur_mode = csoc_pkg::CSOC_CUR_LOW;
            csoc_pkg::CSOC_RNG_MED: analog_next.cur_mode = csoc_pkg::CSOC_CUR_MED;
            default:                analog_next.cur_mode = csoc_pkg::CSOC_CUR_HIGH;
        endcase
        // noise mode keeps comparator and pad alive, source dropped
        analog_next.src_off = (rng == csoc_pkg::CSOC_RNG_ZERO);
        analog_next.osc_on  = en &&
            (vref || rng != csoc_pkg::CSOC_RNG_ZERO);
    end

    // count ticks toward the two timers
    always_comb begin
        logic t1_run;
        logic t1_src;
        t1_run = 1'b0;
        t1_src = 1'b0;
        div_next = div_reg + 2'h1;
        // timer zero: oscillator when external select set and source bit
        // clear, its pin when the source bit is set, else the core tick
        if (!taux_reg[csoc_pkg::CSOC_B_T0CS]
            && ctrl0_reg[csoc_pkg::CSOC_B_T0EXT]) begin
            t0tick_next = osc_rise;
        end else if (taux_reg[csoc_pkg::CSOC_B_T0CS]) begin
            t0tick_next = t0p_rise;
        end else begin
            t0tick_next = (div_reg == csoc_pkg::CSOC_FOSC4_LAST);
        end
        // timer one source select
        case (t1ctl_reg[csoc_pkg::CSOC_B_T1CS_HI:csoc_pkg::CSOC_B_T1CS_LO])
            csoc_pkg::CSOC_T1CS_SNS:  t1_src = osc_rise;
            csoc_pkg::CSOC_T1CS_FOSC: t1_src = 1'b1;
            csoc_pkg::CSOC_T1CS_PIN:  t1_src = t1p_rise;
            default: t1_src = (div_reg == csoc_pkg::CSOC_FOSC4_LAST);
        endcase
        // off, free running, or counting while the gate allows
        t1_run = t1ctl_reg[csoc_pkg::CSOC_B_T1ON] &&
                 (!taux_reg[csoc_pkg::CSOC_B_T1GE] || gate_lvl);
        t1tick_next = t1_run & t1_src;
    end

    // one register process for all state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl0_reg   <= csoc_pkg::CSOC_RST_CTRL0;
            ctrl1_reg   <= csoc_pkg::CSOC_RST_CTRL1;
            t1ctl_reg   <= csoc_pkg::CSOC_RST_T1CTL;
            taux_reg    <= csoc_pkg::CSOC_RST_TAUX;
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            analog_reg  <= '{chan_en: 8'h00, osc_on: 1'b0, src_off: 1'b1,
                             ref_lo_dac: 1'b0, ref_hi_vref: 1'b0,
                             cur_mode: csoc_pkg::CSOC_CUR_OFF};
            t0tick_reg  <= 1'b0;
            t1tick_reg  <= 1'b0;
            div_reg     <= 2'h0;
        end else begin
            ctrl0_reg   <= ctrl0_next;
            ctrl1_reg   <= ctrl1_next;
            t1ctl_reg   <= t1ctl_next;
            taux_reg    <= taux_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            analog_reg  <= analog_next;
            t0tick_reg  <= t0tick_next;
            t1tick_reg  <= t1tick_next;
            div_reg     <= div_next;
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign analog_ctrl = analog_reg;
    assign tmr0_tick   = t0tick_reg;
    assign tmr1_tick   = t1tick_reg;

    // checks on the block's own outputs
    property p_ref_select;
        @(posedge clk) disable iff (!rst_n)
        ##1 analog_reg.ref_lo_dac == $past(ctrl0_reg[csoc_pkg::CSOC_B_REFM]);
    endproperty
    a_ref_select: assert property (p_ref_select)
        else $error("reference source does not follow mode bit");

    property p_fixed_rails;
        @(posedge clk) disable iff (!rst_n)
        !ctrl0_reg[csoc_pkg::CSOC_B_REFM]
            |=> !analog_reg.ref_lo_dac && !analog_reg.ref_hi_vref;
    endproperty
    a_fixed_rails: assert property (p_fixed_rails)
        else $error("fixed mode not on supply rails");

    property p_var_refs;
        @(posedge clk) disable iff (!rst_n)
        ctrl0_reg[csoc_pkg::CSOC_B_REFM]
            |=> analog_reg.ref_lo_dac && analog_reg.ref_hi_vref;
    endproperty
    a_var_refs: assert property (p_var_refs)
        else $error("variable mode not on dac and voltage reference");

    property p_range_zero;
        @(posedge clk) disable iff (!rst_n)
        ctrl0_reg[3:2] == 2'h0 |=> analog_reg.cur_mode ==
            ($past(ctrl0_reg[csoc_pkg::CSOC_B_REFM]) ?
             csoc_pkg::CSOC_CUR_NOISE : csoc_pkg::CSOC_CUR_OFF);
    endproperty
    a_range_zero: assert property (p_range_zero)
        else $error("range code zero decoded wrongly");

    property p_noise_mode;
        @(posedge clk) disable iff (!rst_n)
        analog_reg.cur_mode == csoc_pkg::CSOC_CUR_NOISE
            && $past(ctrl0_reg[csoc_pkg::CSOC_B_ENABLE])
            |-> analog_reg.src_off && analog_reg.osc_on;
    endproperty
    a_noise_mode: assert property (p_noise_mode)
        else $error("noise mode must drop source and keep oscillator");

    property p_phase_read;
        @(posedge clk) disable iff (!rst_n)
        setup_ph && paddr == csoc_pkg::CSOC_OFF_CTRL0
            |=> prdata_reg[csoc_pkg::CSOC_B_PHASE] == $past(phase_lvl);
    endproperty
    a_phase_read: assert property (p_phase_read)
        else $error("phase status bit not read back");

    property p_chan_conn;
        @(posedge clk) disable iff (!rst_n)
        ctrl0_reg[csoc_pkg::CSOC_B_ENABLE] && !ctrl1_reg[3]
            |=> analog_reg.chan_en == (8'h01 << $past(ctrl1_reg[2:0]));
    endproperty
    a_chan_conn: assert property (p_chan_conn)
        else $error("selected channel not connected");

    property p_chan_off;
        @(posedge clk) disable iff (!rst_n)
        !ctrl0_reg[csoc_pkg::CSOC_B_ENABLE] || ctrl1_reg[3]
            |=> analog_reg.chan_en == 8'h00;
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("channel connected while disabled or reserved");

    property p_t0_sense;
        @(posedge clk) disable iff (!rst_n)
        !taux_reg[csoc_pkg::CSOC_B_T0CS] && ctrl0_reg[csoc_pkg::CSOC_B_T0EXT]
            |=> tmr0_tick == $past(osc_rise);
    endproperty
    a_t0_sense: assert property (p_t0_sense)
        else $error("timer zero not clocked by oscillator");

    property p_t1_sense;
        @(posedge clk) disable iff (!rst_n)
        t1ctl_reg[7:6] == csoc_pkg::CSOC_T1CS_SNS
            && t1ctl_reg[csoc_pkg::CSOC_B_T1ON]
            && !taux_reg[csoc_pkg::CSOC_B_T1GE]
            |=> tmr1_tick == $past(osc_rise);
    endproperty
    a_t1_sense: assert property (p_t1_sense)
        else $error("timer one not clocked by oscillator");

    property p_t1_gate;
        @(posedge clk) disable iff (!rst_n)
        !t1ctl_reg[csoc_pkg::CSOC_B_T1ON]
            || (taux_reg[csoc_pkg::CSOC_B_T1GE] && !gate_lvl)
            |=> !tmr1_tick;
    endproperty
    a_t1_gate: assert property (p_t1_gate)
        else $error("timer one counted while off or gated");

    property p_enable;
        @(posedge clk) disable iff (!rst_n)
        !ctrl0_reg[csoc_pkg::CSOC_B_ENABLE] |=> !analog_reg.osc_on;
    endproperty
    a_enable: assert property (p_enable)
        else $error("oscillator on while module disabled");

endmodule // csoc_top

// File: test/csoc_osc_model.sv
// far-side model: sensing oscillator source and timer counters
`timescale 1ns/100ps
module csoc_osc_model #(
    parameter int HALF = 4 // half period in clocks, above sync limit
) (
    input  wire logic        clk,
    input  wire logic        run,       // oscillate while high
    input  wire logic        lvl,       // level held while stopped
    input  wire logic        clr,       // clear both counters
    input  wire logic        tmr0_tick,
    input  wire logic        tmr1_tick,
    output logic             osc_comp,  // comparator, high = sourcing
    output logic [15:0]      cnt0,      // timer zero count
    output logic [15:0]      cnt1       // timer one count
);
    logic [7:0] ph; // clocks into the current half period
    initial osc_comp = 1'b0;
    // square stand-in; stands still outside a measurement window
    always @(posedge clk) begin
        if (!run) begin
            ph       <= 8'h00;
            osc_comp <= lvl;
        end else if (ph == 8'(HALF - 1)) begin
            ph       <= 8'h00;
            osc_comp <= !osc_comp;
        end else begin
            ph <= ph + 8'h01;
        end
    end
    // time base is the bench clock, never the timer being counted
    always @(posedge clk) begin
        if (clr) begin
            cnt0 <= 16'h0000;
            cnt1 <= 16'h0000;
        end else begin
            cnt0 <= cnt0 + 16'(tmr0_tick);
            cnt1 <= cnt1 + 16'(tmr1_tick);
        end
    end
endmodule // csoc_osc_model

// File: test/cap_sense_osc_control_bench.sv
// self-checking bench for the sensing oscillator control block
`timescale 1ns/100ps
module cap_sense_osc_control_bench;
    logic                   clk = 1'b0;     // 20 mhz
    logic                   rst_n = 1'b0;   // synchronous, active low
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0000_0000;
    logic [3:0]             pstrb = 4'h0;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   osc_comp;
    logic                   t1_gate = 1'b0; // timer one gate level
    csoc_pkg::csoc_analog_t analog_ctrl;
    logic                   tmr0_tick;
    logic                   tmr1_tick;
    logic                   run = 1'b0;     // model oscillates
    logic                   lvl = 1'b0;     // model still level
    logic                   clr = 1'b0;
    logic [15:0]            cnt0;
    logic [15:0]            cnt1;
    int                     miscompares = 0;
    int                     total_checks = 0;

    always #25 clk = ~clk;

    csoc_top u_csoc_top (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_comp(osc_comp),
        .t0_pin(1'b0), .t1_pin(1'b0), .t1_gate(t1_gate),
        .analog_ctrl(analog_ctrl), .tmr0_tick(tmr0_tick),
        .tmr1_tick(tmr1_tick));

    csoc_osc_model u_csoc_osc_model (.clk(clk), .run(run), .lvl(lvl),
        .clr(clr), .tmr0_tick(tmr0_tick), .tmr1_tick(tmr1_tick),
        .osc_comp(osc_comp), .cnt0(cnt0), .cnt1(cnt1));

    // counts and verdict, the single exit
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; request held until pready seen at an edge
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            miscompares++;
            $display("ERROR apb no pready");
            wrap_up;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, {24'h00_0000, d}, q, e);
        repeat (2) @(posedge clk); // analog outputs settle
    endtask

    // expected analog control for a given register setting
    function automatic csoc_pkg::csoc_analog_t exp_an(logic en, logic rm,
                                    logic [1:0] rg, logic [3:0] ch);
        csoc_pkg::csoc_analog_t a;
        a.chan_en    = (en && !ch[3]) ? 8'h01 << ch[2:0] : 8'h00;
        a.osc_on     = en && (rm || rg != 2'h0);
        a.src_off    = (rg == 2'h0);
        a.ref_lo_dac = rm;
        a.ref_hi_vref = rm;
        case (rg)
            2'h0:    a.cur_mode = rm ? csoc_pkg::CSOC_CUR_NOISE
                                     : csoc_pkg::CSOC_CUR_OFF;
            2'h1:    a.cur_mode = csoc_pkg::CSOC_CUR_LOW;
            2'h2:    a.cur_mode = csoc_pkg::CSOC_CUR_MED;
            default: a.cur_mode = csoc_pkg::CSOC_CUR_HIGH;
        endcase
        return a;
    endfunction

    // reset values, masks, read-only phase bit, unmapped address
    task automatic t_map;
        logic [7:0]  m [4];
        logic [31:0] q;
        logic        e;
        m = '{csoc_pkg::CSOC_MSK_CTRL0, csoc_pkg::CSOC_MSK_CTRL1,
              csoc_pkg::CSOC_MSK_T1CTL, csoc_pkg::CSOC_MSK_TAUX};
        chk("analog reset", 32'(exp_an(0, 0, 2'h0, 4'h0)),
            32'(analog_ctrl));
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000, q, e);
            chk("reset value", 32'h0000_0000, q);
            apb(1'b1, 8'(i * 4), 32'hFFFF_FFFF, q, e);
            apb(1'b0, 8'(i * 4), 32'h0000_0000, q, e);
            chk("mask readback", {24'h00_0000, m[i]}, q);
            chk("mapped error", 32'h0000_0000, 32'(e));
            apb(1'b1, 8'(i * 4), 32'h0000_0000, q, e);
        end
        apb(1'b0, 8'h10, 32'h0000_0000, q, e);
        chk("unmapped error", 32'h0000_0001, 32'(e));
        chk("unmapped data", 32'h0000_0000, q);
    endtask

    // every reference mode and current range code, module enabled
    task automatic t_decode;
        for (int rm = 0; rm < 2; rm++)
            for (int rg = 0; rg < 4; rg++) begin
                wr(csoc_pkg::CSOC_OFF_CTRL0, 8'(8'h80 | rm << 6 | rg << 2));
                chk("decode", 32'(exp_an(1, rm[0], rg[1:0], 4'h0)),
                    32'(analog_ctrl));
            end
    endtask

    // all sixteen channel codes, enabled and disabled
    task automatic t_chan;
        csoc_pkg::csoc_analog_t x;
        for (int en = 0; en < 2; en++)
            for (int ch = 0; ch < 16; ch++) begin
                wr(csoc_pkg::CSOC_OFF_CTRL1, 8'(ch));
                wr(csoc_pkg::CSOC_OFF_CTRL0, 8'(en << 7 | 8'h04));
                x = exp_an(en[0], 1'b0, 2'h1, 4'(ch));
                chk("channel", {23'h00_0000, x.chan_en, x.osc_on},
                    {23'h00_0000, analog_ctrl.chan_en,
                     analog_ctrl.osc_on});
            end
    endtask

    // phase status follows a comparator held still
    task automatic t_phase;
        logic [31:0] q;
        logic        e;
        for (int v = 1; v >= 0; v--) begin
            lvl <= v[0];
            repeat (8) @(posedge clk);
            apb(1'b0, csoc_pkg::CSOC_OFF_CTRL0, 32'h0000_0000, q, e);
            chk("phase bit", 32'(v), 32'(q[1]));
        end
    endtask

    // k oscillator periods between cleared and settled counters
    task automatic osc(int k);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        run <= 1'b1;
        repeat (8 * k) @(posedge clk);
        run <= 1'b0;
        repeat (12) @(posedge clk);
    endtask

    // timer one from the oscillator: off, free, gated low and high
    task automatic t_tmr1;
        wr(csoc_pkg::CSOC_OFF_TAUX, 8'h00);
        wr(csoc_pkg::CSOC_OFF_T1CTL, 8'hC1);
        osc(5);
        chk("t1 free", 32'd5, 32'(cnt1));
        wr(csoc_pkg::CSOC_OFF_T1CTL, 8'hC0);
        osc(5);
        chk("t1 off", 32'd0, 32'(cnt1));
        wr(csoc_pkg::CSOC_OFF_T1CTL, 8'hC1);
        wr(csoc_pkg::CSOC_OFF_TAUX, 8'h02);
        osc(5);
        chk("t1 gate low", 32'd0, 32'(cnt1));
        t1_gate <= 1'b1;
        osc(6);
        chk("t1 gate high", 32'd6, 32'(cnt1));
    endtask

    // timer zero from the oscillator, timer one stopped
    task automatic t_tmr0;
        wr(csoc_pkg::CSOC_OFF_T1CTL, 8'h00);
        wr(csoc_pkg::CSOC_OFF_TAUX, 8'h00);
        wr(csoc_pkg::CSOC_OFF_CTRL0, 8'h85);
        osc(7);
        chk("t0 count", 32'd7, 32'(cnt0));
        chk("t1 idle", 32'd0, 32'(cnt1));
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_map;
        t_decode;
        t_chan;
        t_phase;
        t_tmr1;
        t_tmr0;
        wrap_up;
    end
endmodule // cap_sense_osc_control_bench
